// >>> rtl/rx_alarm_status_bits.sv
// Per-channel receive alarm status registers behind a Wishbone slave
//
// What this block does
// R1: Analog LOS declares below declaration threshold; the code declares it at DS3 or STS-1 rate only and holds it clear at E3
// R2: Analog LOS clears above separate clearance threshold
// R3: Analog LOS status bit reads detector state
// R4: Channel LOS is analog OR digital
// R5: Combined LOS readable at status bit 1
// R6: FIFO alarm within two bits of limits
// R7: FIFO alarm clears beyond two-bit margin
// R8: FIFO alarm bit reads 1 when declared
// R9: FIFO alarm inactive unless attenuator enabled
// R10: Lock lost at 0.5% from reference
// R11: Synthesizer mode compares against synthesized clock
// R12: Lock status bit 2 reads 0 locked
// R13: Lock status bit reads 1 when unlocked
// R14: Digital LOS: 160 zeros declare, 33% clears; the code runs it at DS3 or STS-1 rate only and holds it clear at E3
`include "rx_alarm_params.svh"
module rx_alarm_status_bits (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             rate_a_reference_clock,
  input  wire logic             rate_b_reference_clock,
  input  wire logic             rate_c_reference_clock,
  input  wire logic [2:0]       synth_line_clk,
  input  wire logic [2:0]       recovered_clk,
  input  wire logic [2:0]       line_bit_clk,
  input  wire logic [2:0]       line_pulse,
  input  wire logic [2:0]       analog_above_clear,
  input  wire logic [2:0]       analog_below_declare,
  input  wire logic [2:0][5:0]  ja_fill_gray
);

  typedef struct packed {
    rx_alarm_pkg::pin_type            s1;
    rx_alarm_pkg::pin_type            s2;
    rx_alarm_pkg::clk_type            prev;
    rx_alarm_pkg::chan_cfg_type [2:0] cfg;
    logic [2:0]                       analog_los;
    logic [2:0]                       fl;
    logic                             ack;
    logic [31:0]                      rdata;
  } top_state_type;

  typedef struct packed {
    logic       status;
    logic       setup;
    logic [1:0] ch;
  } reg_hit_type;

  top_state_type         q, d;
  rx_alarm_pkg::pin_type pins;
  rx_alarm_pkg::clk_type edges;
  logic [2:0]            digital_los;
  logic [2:0]            unlocked;
  logic [2:0]            ref_sel;
  logic [2:0]            dlos_active;
  logic [2:0]            los_comb;
  logic [2:0][5:0]       fill;
  logic [2:0][7:0]       status;

  // Address decode shared by reads and writes
  function automatic reg_hit_type decode_reg(input logic [7:0] adr);
    reg_hit_type h;
    h = '0;
    for (int c = 0; c < 3; c++) begin
      if (adr == `REG_STATUS0 + 8'(c) * `REG_STRIDE) begin
        h.status = 1'b1;
        h.ch = 2'(c);
      end
      if (adr == `REG_CONFIG0 + 8'(c) * `REG_STRIDE) begin
        h.setup = 1'b1;
        h.ch = 2'(c);
      end
    end
    return h;
  endfunction : decode_reg

  // Gray fill count keeps the pin word safe to sample bit by bit
  function automatic logic [5:0] gray_to_bin(input logic [5:0] g);
    logic [5:0] b;
    b = '0;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  // Reference picked by rate unless the synthesizer supplies it
  function automatic logic pick_ref(
    input rx_alarm_pkg::chan_cfg_type cfg,
    input logic                       synth,
    input logic [2:0]                 refs);
    logic r;
    r = 1'b0;
    if (cfg.single_ref_synth_operation) begin
      r = synth;
    end else begin
      unique case (cfg.rate)
        rx_alarm_pkg::RATE_E3:   r = refs[0];
        rx_alarm_pkg::RATE_DS3:  r = refs[1];
        rx_alarm_pkg::RATE_STS1: r = refs[2];
        default:                 r = 1'b0;
      endcase
    end
    return r;
  endfunction : pick_ref

  // Gather every line-side pin, not the bus pins, for the two-stage synchroniser
  always_comb begin
    pins.clk.ref_clk = {rate_c_reference_clock,
                        rate_b_reference_clock,
                        rate_a_reference_clock};
    pins.clk.synth_clk = synth_line_clk;
    pins.clk.rec_clk = recovered_clk;
    pins.clk.bit_clk = line_bit_clk;
    pins.line_pulse = line_pulse;
    pins.above_clear = analog_above_clear;
    pins.below_declare = analog_below_declare;
    pins.fill_gray = ja_fill_gray;
  end

  // Rising edges seen only after the second stage
  assign edges = q.s2.clk & ~q.prev;

  // Per-channel derived values and status bytes
  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      assign fill[c] = gray_to_bin(q.s2.fill_gray[c]);
      assign dlos_active[c] =
        q.cfg[c].rate == rx_alarm_pkg::RATE_DS3 ||
        q.cfg[c].rate == rx_alarm_pkg::RATE_STS1;
      assign ref_sel[c] = pick_ref(q.cfg[c], // R11
                                   edges.synth_clk[c],
                                   edges.ref_clk);
      assign los_comb[c] = q.analog_los[c] | digital_los[c]; // R4

      // Bit 0 belongs to the transmit monitor and reads zero here
      always_comb begin
        status[c] = 8'h00;
        status[c][`ST_LOS] = los_comb[c]; // R5
        status[c][`ST_LOL] = unlocked[c]; // R12 R13
        status[c][`ST_FL] = q.fl[c]; // R8
        status[c][`ST_ALOS] = q.analog_los[c]; // R3
        status[c][`ST_DLOS] = digital_los[c];
      end

      digital_los_detect u_dlos (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .active       (dlos_active[c]),
        .bit_tick     (edges.bit_clk[c]),
        .pulse        (q.s2.line_pulse[c]),
        .los_declared (digital_los[c])
      );

      lock_freq_monitor u_lol (
        .clk_sys                  (clk_sys),
        .reset_n                  (reset_n),
        .ref_edge                 (ref_sel[c]),
        .rec_edge                 (edges.rec_clk[c]),
        .recovered_clock_unlocked (unlocked[c])
      );
    end
  endgenerate

  // Next state: detectors, alarms and the bus slave
  always_comb begin
    reg_hit_type       hit;
    logic        [5:0] depth;
    hit = decode_reg(wb_adr_i);
    depth = 6'h00;
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.prev = q.s2.clk;

    for (int c = 0; c < 3; c++) begin
      // Hysteresis: at DS3 or STS-1 rate only the clearance comparator can release; E3 rate forces it clear
      if (!dlos_active[c]) begin
        d.analog_los[c] = 1'b0;
      end else if (q.s2.below_declare[c]) begin
        d.analog_los[c] = 1'b1; // R1
      end else if (q.s2.above_clear[c]) begin
        d.analog_los[c] = 1'b0; // R2
      end

      depth = q.cfg[c].ja_depth32 ? `FIFO_DEPTH_L : `FIFO_DEPTH_S;
      if (!q.cfg[c].ja_enable) begin
        d.fl[c] = 1'b0; // R9
      end else begin
        d.fl[c] = fill[c] <= `FL_MARGIN || // R6 R7
                  fill[c] + `FL_MARGIN >= depth;
      end
    end

    // Answer one cycle after the request, then drop for a cycle
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.rdata = 32'h0000_0000;
      if (hit.status) begin
        d.rdata[7:0] = status[hit.ch];
      end else if (hit.setup) begin
        d.rdata[4:0] = q.cfg[hit.ch];
      end
      if (wb_we_i && hit.setup && wb_sel_i[0]) begin
        d.cfg[hit.ch] = rx_alarm_pkg::chan_cfg_type'(wb_dat_i[4:0]);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      for (int c = 0; c < 3; c++) begin
        q.cfg[c] <= rx_alarm_pkg::chan_cfg_type'(`CFG_RESET);
      end
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_read_status0;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h00;
  endsequence

  a_analog_declare: assert property ( // R1
    dlos_active[0] && q.s2.below_declare[0] |=> q.analog_los[0])
    else $error("analog LOS not declared below threshold");

  a_analog_hold: assert property ( // R2
    dlos_active[0] && q.analog_los[0] && !q.s2.above_clear[0]
    |=> q.analog_los[0])
    else $error("analog LOS released without clearance level");

  a_analog_read: assert property ( // R3
    s_read_status0 |=> wb_ack_o &&
    wb_dat_o[`ST_ALOS] == $past(q.analog_los[0]))
    else $error("analog LOS bit mismatch on read");

  a_los_or_read: assert property ( // R5
    s_read_status0 |=> wb_dat_o[`ST_LOS] ==
    ($past(q.analog_los[0]) | $past(digital_los[0])))
    else $error("combined LOS bit is not the OR");

  a_fifo_near: assert property ( // R6
    q.cfg[0].ja_enable && fill[0] <= 6'h02 |=> q.fl[0])
    else $error("FIFO limit alarm missed near underrun");

  a_fifo_far: assert property ( // R7
    q.cfg[0].ja_enable && !q.cfg[0].ja_depth32 &&
    fill[0] > 6'h02 && fill[0] < 6'h0E |=> !q.fl[0])
    else $error("FIFO limit alarm held with margin");

  a_fifo_disabled: assert property ( // R9
    !q.cfg[0].ja_enable |=> !q.fl[0])
    else $error("FIFO limit alarm with attenuator off");

  a_fifo_read: assert property ( // R8
    s_read_status0 |=> wb_dat_o[`ST_FL] == $past(q.fl[0]))
    else $error("FIFO limit bit mismatch on read");

  a_lol_read: assert property ( // R12
    s_read_status0 |=> wb_dat_o[`ST_LOL] == $past(unlocked[0]))
    else $error("loss of lock bit mismatch on read");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : rx_alarm_status_bits

// >>> pkg/rx_alarm_params.svh
// Offsets, field positions, reset values and counts of the alarm block
`ifndef RX_ALARM_PARAMS_SVH
`define RX_ALARM_PARAMS_SVH
// Register byte offsets, one word per channel
`define REG_STATUS0  8'h00
`define REG_CONFIG0  8'h10
`define REG_STRIDE   8'h04
// Status bit positions
`define ST_LOS       1
`define ST_LOL       2
`define ST_FL        3
`define ST_ALOS      4
`define ST_DLOS      5
// Config reset: DS3, jitter attenuator off, 16-bit FIFO
`define CFG_RESET    5'h01
// Digital detector: zero run and density window, in bit periods
`define DLOS_ZERO_RUN   8'hA0
`define DLOS_WINDOW     6'h20
`define DLOS_CLEAR_PCT  33
`define DLOS_CLEAR_N \
  ((32 * `DLOS_CLEAR_PCT + 99) / 100)
// Jitter attenuator FIFO margin and depths, in bit periods
`define FL_MARGIN    6'h02
`define FIFO_DEPTH_S 6'h10
`define FIFO_DEPTH_L 6'h20
// Lock monitor: window in reference edges, deviation in ppm
`define LOL_WINDOW   12'h7D0
`define LOL_WINDOW_N 2000
`define LOL_PPM      5000
`define LOL_LIMIT_N  (`LOL_WINDOW_N * `LOL_PPM / 1000000)
`endif

// >>> pkg/rx_alarm_pkg.sv
// Types shared by the receive alarm status block
package rx_alarm_pkg;
  typedef enum logic [1:0] {RATE_E3, RATE_DS3, RATE_STS1} line_rate_type;

  typedef struct packed {
    logic          single_ref_synth_operation;
    logic          ja_depth32;
    logic          ja_enable;
    line_rate_type rate;
  } chan_cfg_type;

  // Clock-like pins, all sampled and edge detected
  typedef struct packed {
    logic [2:0] ref_clk;
    logic [2:0] synth_clk;
    logic [2:0] rec_clk;
    logic [2:0] bit_clk;
  } clk_type;

  typedef struct packed {
    clk_type         clk;
    logic [2:0]      line_pulse;
    logic [2:0]      above_clear;
    logic [2:0]      below_declare;
    logic [2:0][5:0] fill_gray;
  } pin_type;
endpackage : rx_alarm_pkg

// >>> rtl/digital_los_detect.sv
// Digital loss-of-signal detector driven by bit-period ticks
`include "rx_alarm_params.svh"
module digital_los_detect (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic active,
  input  wire logic bit_tick,
  input  wire logic pulse,
  output logic      los_declared
);
  typedef struct packed {
    logic [7:0] zero_run;
    logic [5:0] win_cnt;
    logic [5:0] win_pulses;
    logic       los;
  } dlos_state_type;

  dlos_state_type q, d;
  localparam logic [5:0] CLEAR_N = 6'(`DLOS_CLEAR_N);

  // Zero run declares, pulse density over a window clears
  always_comb begin
    d = q;
    if (!active) begin
      d = '0;
    end else if (bit_tick) begin
      d.zero_run = pulse ? 8'h00 :
        (q.zero_run == `DLOS_ZERO_RUN) ? q.zero_run : q.zero_run + 8'h01;
      d.win_pulses = q.win_pulses + {5'h00, pulse};
      d.win_cnt = q.win_cnt + 6'h01;
      if (d.win_cnt == `DLOS_WINDOW) begin
        d.win_cnt = 6'h00;
        d.win_pulses = 6'h00;
        if (q.win_pulses + {5'h00, pulse} >= CLEAR_N) begin
          d.los = 1'b0; // R14
        end
      end
      // Declaring wins over a density clear in the same tick
      if (d.zero_run == `DLOS_ZERO_RUN) begin
        d.los = 1'b1; // R14
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign los_declared = q.los;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_dlos_run_declares: assert property ( // R14
    active && bit_tick && !pulse && q.zero_run == 8'h9F
    |=> los_declared)
    else $error("digital LOS not declared after zero run");
  a_dlos_idle_clear: assert property ( // R14
    !active |=> !los_declared)
    else $error("digital LOS active outside DS3 or STS-1");
endmodule : digital_los_detect

// >>> rtl/lock_freq_monitor.sv
// Recovered clock against reference clock frequency check
`include "rx_alarm_params.svh"
module lock_freq_monitor (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic ref_edge,
  input  wire logic rec_edge,
  output logic      recovered_clock_unlocked
);
  typedef struct packed {
    logic [11:0] ref_cnt;
    logic [11:0] rec_cnt;
    logic        unlocked;
  } lol_state_type;

  lol_state_type q, d;
  logic [11:0] rec_total;
  logic [11:0] dev;
  logic        win_end;
  localparam logic [11:0] LIMIT = 12'(`LOL_LIMIT_N);

  // Deviation of recovered edges over one reference window
  always_comb begin
    rec_total = q.rec_cnt + {11'h000, rec_edge};
    dev = (rec_total >= `LOL_WINDOW) ? rec_total - `LOL_WINDOW
                                     : `LOL_WINDOW - rec_total;
    win_end = ref_edge && (q.ref_cnt == `LOL_WINDOW - 12'h001);
  end

  // A stopped reference freezes the verdict; a stopped line unlocks
  always_comb begin
    d = q;
    if (win_end) begin
      d.unlocked = dev >= LIMIT; // R10 R13
      d.ref_cnt = 12'h000;
      d.rec_cnt = 12'h000;
    end else begin
      if (ref_edge) begin
        d.ref_cnt = q.ref_cnt + 12'h001;
      end
      if (rec_edge && q.rec_cnt != 12'hFFF) begin
        d.rec_cnt = q.rec_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign recovered_clock_unlocked = q.unlocked;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_window_end;
    ref_edge && q.ref_cnt == 12'h7CF;
  endsequence
  a_lol_declare: assert property ( // R10
    s_window_end and (dev >= 12'h00A) |=> recovered_clock_unlocked)
    else $error("loss of lock not declared at 0.5 percent");
  a_lol_clear: assert property ( // R12
    s_window_end and (dev < 12'h00A) |=> !recovered_clock_unlocked)
    else $error("loss of lock held within tolerance");
endmodule : lock_freq_monitor

// >>> testbench/rx_alarm_status_bits_tb.sv
// Self-checking bench for the receive alarm status block
module rx_alarm_status_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk_sys;
  logic             reset_n;
  logic             wb_cyc_i;
  logic             wb_stb_i;
  logic             wb_we_i;
  logic [7:0]       wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic             rate_a_reference_clock;
  logic             rate_b_reference_clock;
  logic             rate_c_reference_clock;
  logic [2:0]       synth_line_clk;
  logic [2:0]       recovered_clk;
  logic [2:0]       line_bit_clk;
  logic [2:0]       line_pulse;
  logic [2:0]       analog_above_clear;
  logic [2:0]       analog_below_declare;
  logic [2:0][5:0]  ja_fill_gray;
  logic [31:0]      exp_q[$];
  logic [31:0]      seed;
  int               err_total;
  int               num_checks;
  int               cyc_cnt;
  int               ref_h, rec_h, syn_h, ref_c, rec_c, syn_c;

  rx_alarm_status_bits rx_alarm_status_bits_inst (
    .clk_sys                (clk_sys),
    .reset_n                (reset_n),
    .wb_cyc_i               (wb_cyc_i),
    .wb_stb_i               (wb_stb_i),
    .wb_we_i                (wb_we_i),
    .wb_adr_i               (wb_adr_i),
    .wb_sel_i               (wb_sel_i),
    .wb_dat_i               (wb_dat_i),
    .wb_dat_o               (wb_dat_o),
    .wb_ack_o               (wb_ack_o),
    .rate_a_reference_clock (rate_a_reference_clock),
    .rate_b_reference_clock (rate_b_reference_clock),
    .rate_c_reference_clock (rate_c_reference_clock),
    .synth_line_clk         (synth_line_clk),
    .recovered_clk          (recovered_clk),
    .line_bit_clk           (line_bit_clk),
    .line_pulse             (line_pulse),
    .analog_above_clear     (analog_above_clear),
    .analog_below_declare   (analog_below_declare),
    .ja_fill_gray           (ja_fill_gray)
  );

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  function automatic logic [5:0] gray(input int b);
    return 6'(b ^ (b >> 1));
  endfunction : gray

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc

  // Classic single cycle; entered just after a rising edge
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("mismatch at %0t: no acknowledge", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Channel 0 bit periods; pulse presence set together with each rising edge
  task automatic edges(input int n, input logic p);
    repeat (n) begin
      line_pulse[0]   <= p;
      line_bit_clk[0] <= 1'b1;
      wait_cyc(2);
      line_bit_clk[0] <= 1'b0;
      wait_cyc(2);
    end
  endtask : edges

  // Read results come back in request order, so a queue suffices
  always @(negedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("mismatch at %0t: unexpected read data", $time);
      end else
        check(wb_dat_o, exp_q.pop_front());
    end
  end

  // Divided reference, recovered and synthesizer clocks; 0 stops one
  always @(posedge clk_sys) begin
    if (ref_h > 0 && ++ref_c >= ref_h) begin
      ref_c = 0;
      rate_b_reference_clock <= ~rate_b_reference_clock;
    end
    if (rec_h > 0 && ++rec_c >= rec_h) begin
      rec_c = 0;
      recovered_clk <= ~recovered_clk;
    end
    if (syn_h > 0 && ++syn_c >= syn_h) begin
      syn_c = 0;
      synth_line_clk <= ~synth_line_clk;
    end
  end

  // Hang guard, sized well above the lock windows below
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 90000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    int f;
    int ch;
    err_total = 0;
    num_checks = 0;
    cyc_cnt = 0;
    seed = 32'hD819;
    {ref_h, rec_h, syn_h, ref_c, rec_c, syn_c} = '0;
    reset_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    {rate_a_reference_clock, rate_b_reference_clock} = 2'h0;
    rate_c_reference_clock = 1'b0;
    {synth_line_clk, recovered_clk, line_bit_clk, line_pulse} = '0;
    analog_above_clear = 3'h0;
    analog_below_declare = 3'h0;
    ja_fill_gray = {3{gray(16)}};
    wait_cyc(2);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // Reset values, unmapped place, read-only status
    for (ch = 0; ch < 3; ch++) begin
      rd(8'(ch * 4), 32'h0000_0000);
      rd(8'(8'h10 + ch * 4), 32'h0000_0001);
    end
    xfer(1'b1, 8'h00, 32'h0000_00FF);
    xfer(1'b1, 8'h20, 32'h0000_00FF);
    rd(8'h00, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    // Analog detector with hysteresis, each channel
    for (ch = 0; ch < 3; ch++) begin
      analog_below_declare <= 3'(1 << ch);
      wait_cyc(6);
      rd(8'(ch * 4), 32'h0000_0012);
      analog_below_declare <= 3'h0;
      wait_cyc(6);
      rd(8'(ch * 4), 32'h0000_0012);
      analog_above_clear <= 3'(1 << ch);
      wait_cyc(6);
      rd(8'(ch * 4), 32'h0000_0000);
      analog_above_clear <= 3'h0;
    end
    // E3 rate keeps the analog detector out of the status
    xfer(1'b1, 8'h10, 32'h0000_0000);
    analog_below_declare <= 3'h1;
    wait_cyc(6);
    rd(8'h00, 32'h0000_0000);
    analog_below_declare <= 3'h0;
    analog_above_clear <= 3'h1;
    wait_cyc(6);
    analog_above_clear <= 3'h0;
    xfer(1'b1, 8'h10, 32'h0000_0001);
    // FIFO alarm: off while attenuator disabled, then every fill at depth 16 and ten random fills at depth 32
    ja_fill_gray[0] <= gray(1);
    wait_cyc(6);
    rd(8'h00, 32'h0000_0000);
    xfer(1'b1, 8'h10, 32'h0000_0005);
    for (f = 0; f <= 16; f++) begin
      ja_fill_gray[0] <= gray(f);
      wait_cyc(6);
      rd(8'h00, (f <= 2 || f + 2 >= 16) ? 32'h8 : 32'h0);
    end
    xfer(1'b1, 8'h10, 32'h0000_000D);
    repeat (10) begin
      seed = xs(seed);
      f = int'(seed % 33);
      ja_fill_gray[0] <= gray(f);
      wait_cyc(6);
      rd(8'h00, (f <= 2 || f + 2 >= 32) ? 32'h8 : 32'h0);
    end
    xfer(1'b1, 8'h10, 32'h0000_0001);
    // Digital detector: 159 empty periods stay clear, the 160th declares
    edges(159, 1'b0);
    wait_cyc(8);
    rd(8'h00, 32'h0000_0000);
    edges(1, 1'b0);
    wait_cyc(8);
    rd(8'h00, 32'h0000_0022);
    edges(64, 1'b1);
    wait_cyc(8);
    rd(8'h00, 32'h0000_0000);
    // Lock monitor: two full windows after each change
    ref_h = 2;
    rec_h = 2;
    wait_cyc(17000);
    rd(8'h00, 32'h0000_0000);
    rec_h = 3;
    wait_cyc(17000);
    rd(8'h00, 32'h0000_0004);
    rd(8'h04, 32'h0000_0004);
    // Synthesizer mode on channel 0 only
    xfer(1'b1, 8'h10, 32'h0000_0011);
    syn_h = 3;
    wait_cyc(25000);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0004);
    wait_cyc(4);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("mismatch at %0t: reads left unanswered", $time);
    end
    conclude();
  end
endmodule : rx_alarm_status_bits_tb
